// file: hw/irc_pkg.sv
// Constants for the imager readout control register bank
//
// Notes on behaviour
// - Restart drops current frame, restarts at first row within two row times.
// - Restart bit self-clears after acting, unless restart-hold is set.
// - With restart-hold set, park at row zero until hold is cleared.
// - Thirteen-bit shutter trim, 0 to 8191, subtracted from exposure length.
// - Exposure is (upper*65536 + lower) * row time minus trim minus constant.
// - Soft halt restores defaults and stops; clearing it resumes; serial port stays alive.
// - Synth control bit 0 powers synthesizer, bit 1 selects it as system clock.
// - Ratio bits 5:0 output divider minus one; post-divider bits 4:0 system divider.
// - Readout bit 14 keeps unsampled rows in reset while skipping rows.
// - Readout bit 10 lets line-valid run during vertical blanking too.
// - Readout bit 9 inverts external trigger input polarity.
// - Readout bit 8 selects on-demand capture waiting for trigger between frames.
// - Readout bit 7 selects simultaneous-release shutter, else rolling shutter.
// - Readout bit 6 times exposure from external trigger, else from counts.
// - Bit 4 enables flash pulse; otherwise flash rests at bit 5 level.
// - Flash asserts at event chosen by bits 3:2.
// - Flash negates at event of bits 1:0; if end not after start, one row.
// - Secondary bits 15/14 mirror active rows/columns; dark lines unaffected.
// - Bit 12 adds dark columns, bit 11 dark rows; restart advised after rows.
// - Bit 6 enables per-line black compensation, else default row offset.
// - Bit 5 sums binned columns, else averages them.
// - Row bin bits 5:4 and row skip bits 2:0; skip not below bin.
// - Column skip bits 2:0 and column bin bits 5:4; skip not below bin.
// - First green digital gain 1 + bits 14:8 / 8; bit 6 doubles analog gain.
// - Change-hold defers frame-synced writes only; after release they apply at next frame start.
package irc_pkg;

  localparam int IRC_NREG = 13;
  localparam int IRC_AW = 8;
  localparam int IRC_DW = 16;

  // Index into the register array
  localparam int IX_OUT_CTL = 0;
  localparam int IX_SW_UPPER = 1;
  localparam int IX_SW_LOWER = 2;
  localparam int IX_SHUTTER_TRIM = 3;
  localparam int IX_SOFT_HALT = 4;
  localparam int IX_SYNTH_CTL = 5;
  localparam int IX_SYNTH_RATIO = 6;
  localparam int IX_SYNTH_POST = 7;
  localparam int IX_RM_PRI = 8;
  localparam int IX_RM_SEC = 9;
  localparam int IX_LINE_ADDR = 10;
  localparam int IX_PIX_ADDR = 11;
  localparam int IX_GREEN1 = 12;

  localparam logic [IRC_AW-1:0] ADDR_RESTART = 8'h0B;
  // Addresses, reset values and frame-sync masks, entry 0 in the low slot
  localparam logic [IRC_NREG-1:0][IRC_AW-1:0] IRC_ADDR = {
    8'h2B, 8'h23, 8'h22, 8'h20, 8'h1E, 8'h12, 8'h11, 8'h10, 8'h0D, 8'h0C, 8'h09, 8'h08, 8'h07};
  localparam logic [IRC_NREG-1:0][IRC_DW-1:0] IRC_RST = {
    16'h0008, 16'h0000, 16'h0000, 16'h0040, 16'h4006, 16'h0000, 16'h6404, 16'h0050,
    16'h0000, 16'h0000, 16'h0797, 16'h0000, 16'h1F82};
  localparam logic [IRC_NREG-1:0][IRC_DW-1:0] IRC_FSYNC = {
    16'h7F7F, 16'h0037, 16'h0037, 16'hD860, 16'h41CF, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h1FFF, 16'hFFFF, 16'h000F, 16'h0000};

  // Field positions
  localparam int B_HOLD = 0;
  localparam int B_CHIP_EN = 1;
  localparam int B_RESTART = 0;
  localparam int B_PAUSE = 1;
  localparam int B_SWTRIG = 2;
  localparam int B_HALT = 0;
  localparam int B_SYN_PWR = 0;
  localparam int B_SYN_SEL = 1;
  localparam int B_ANTIBLOOM = 14;
  localparam int B_CONT_LV = 10;
  localparam int B_INV_TRIG = 9;
  localparam int B_SNAPSHOT = 8;
  localparam int B_GLOBAL = 7;
  localparam int B_BULB = 6;
  localparam int B_INV_STROBE = 5;
  localparam int B_STROBE_EN = 4;
  localparam int B_MIRROR_ROW = 15;
  localparam int B_MIRROR_COL = 14;
  localparam int B_DARK_COLS = 12;
  localparam int B_DARK_ROWS = 11;
  localparam int B_LINE_BLC = 6;
  localparam int B_COL_SUM = 5;
  localparam int B_DOUBLER = 6;
  localparam int F_TRIM_W = 13;
  localparam int F_UPPER_W = 4;
  localparam int F_GAIN_ONE = 8;
  localparam int RESTART_MAX_ROWS = 2;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_PEND = 3'b010,
    RS_PAUSE = 3'b100
  } irc_rs_t;

endpackage : irc_pkg

// file: hw/irc_regs.sv
// Imager readout control register bank and its control logic
`timescale 1ns/1ps
`default_nettype none
module irc_regs
  import irc_pkg::*;
#(
  parameter int ROW_W = 16,
  parameter logic [15:0] EXPO_FIXED = 16'h0000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [IRC_AW-1:0] reg_addr,
  input wire logic [IRC_DW-1:0] reg_wdata,
  output logic [IRC_DW-1:0] reg_rdata,
  input wire logic pix_ce,
  input wire logic frame_start,
  input wire logic row_tick,
  input wire logic [ROW_W-1:0] row_time,
  input wire logic trigger_pin,
  input wire logic [3:0] strobe_evt,
  input wire logic line_valid_raw,
  input wire logic frame_valid,
  output logic line_valid,
  output logic restart_pulse,
  output logic hold_row0,
  output logic device_halted,
  output logic chip_enable,
  output logic trigger_evt,
  output logic [35:0] exposure_pixclks,
  output logic synth_power,
  output logic synth_select,
  output logic [7:0] synth_multiplier,
  output logic [5:0] synth_out_div,
  output logic [4:0] system_clock_divider,
  output logic anti_bloom,
  output logic snapshot_mode,
  output logic global_shutter,
  output logic bulb_exposure,
  output logic strobe,
  output logic mirror_rows,
  output logic mirror_cols,
  output logic dark_cols,
  output logic dark_rows,
  output logic per_line_black_comp,
  output logic column_sum,
  output logic [1:0] row_bin,
  output logic [2:0] row_skip,
  output logic [1:0] col_bin,
  output logic [2:0] col_skip,
  output logic [7:0] first_green_digital_amp,
  output logic first_green_doubler,
  output logic [5:0] first_green_analog
);

  logic [IRC_NREG-1:0][IRC_DW-1:0] shadow_r;
  logic [IRC_NREG-1:0][IRC_DW-1:0] work_r;
  logic [IRC_NREG-1:0] hit;
  logic halted;
  logic hold;
  logic restart_bit_r;
  logic pause_r;
  logic restart_wr_set;
  logic restart_clr;
  irc_rs_t rs_r;
  logic trig_s1_r;
  logic trig_s2_r;
  logic trig_lvl_d_r;
  logic sw_trig_r;
  logic strobe_act_r;
  logic [ROW_W-1:0] strobe_cnt_r;
  logic [IRC_DW-1:0] rd_mux;
  logic [15:0] lower_eff;
  logic [35:0] expo_prod;
  logic [35:0] expo_cut;
  logic [1:0] st_start;
  logic [1:0] st_end;
  logic short_pulse;

  // halt state lives in working copy of the halt register
  assign halted = work_r[IX_SOFT_HALT][B_HALT];
  assign hold = work_r[IX_OUT_CTL][B_HOLD];
  assign restart_wr_set = reg_wr && (reg_addr == ADDR_RESTART) && reg_wdata[B_RESTART];

  genvar gi;
  generate
    for (gi = 0; gi < IRC_NREG; gi++) begin : g_reg
      assign hit[gi] = (reg_addr == IRC_ADDR[gi]);

      // halt forces defaults, serial writes to halt still taken
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          shadow_r[gi] <= IRC_RST[gi];
        end else if (halted && gi != IX_SOFT_HALT) begin
          shadow_r[gi] <= IRC_RST[gi];
        end else if (reg_wr && hit[gi]) begin
          shadow_r[gi] <= reg_wdata;
        end
      end

      // frame-synced fields move at frame start
      // change-hold defers them; other fields follow at once
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          work_r[gi] <= IRC_RST[gi];
        end else if (halted && gi != IX_SOFT_HALT) begin
          work_r[gi] <= IRC_RST[gi];
        end else if (frame_start && !hold) begin
          work_r[gi] <= shadow_r[gi];
        end else begin
          work_r[gi] <= (work_r[gi] & IRC_FSYNC[gi]) | (shadow_r[gi] & ~IRC_FSYNC[gi]);
        end
      end
    end
  endgenerate

  // Read returns shadow values, or restart_bit_r and pause_r at the restart address, one cycle after the address
  always_comb begin
    rd_mux = '0;
    if (reg_addr == ADDR_RESTART) begin
      rd_mux[B_RESTART] = restart_bit_r;
      rd_mux[B_PAUSE] = pause_r;
    end
    for (int i = 0; i < IRC_NREG; i++) begin
      if (hit[i]) begin
        rd_mux = shadow_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

  // restart sequencer, acts on next row boundary
  always_ff @(posedge ref_clk) begin
    if (!rst_n || halted) begin
      rs_r <= RS_IDLE;
      restart_pulse <= 1'b0;
    end else begin
      restart_pulse <= 1'b0;
      case (rs_r)
        RS_IDLE: begin
          if (restart_bit_r) begin
            rs_r <= RS_PEND;
          end
        end
        RS_PEND: begin
          if (row_tick) begin
            restart_pulse <= 1'b1;
            // park at row zero while hold set
            rs_r <= pause_r ? RS_PAUSE : RS_IDLE;
          end
        end
        RS_PAUSE: begin
          if (!pause_r) begin
            rs_r <= RS_IDLE;
          end
        end
        default: begin
          rs_r <= RS_IDLE;
        end
      endcase
    end
  end

  assign restart_clr = (rs_r == RS_PEND && row_tick && !pause_r) || (rs_r == RS_PAUSE && !pause_r);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || halted) begin
      restart_bit_r <= 1'b0;
      pause_r <= 1'b0;
    end else begin
      if (restart_wr_set) begin
        restart_bit_r <= 1'b1;
      end else if (restart_clr) begin
        restart_bit_r <= 1'b0;
      end
      if (reg_wr && reg_addr == ADDR_RESTART) begin
        pause_r <= reg_wdata[B_PAUSE];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_row0 <= 1'b0;
    end else begin
      hold_row0 <= (rs_r == RS_PAUSE) && !halted;
    end
  end

  // Software trigger, only in on-demand mode, polarity fixed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_trig_r <= 1'b0;
    end else begin
      sw_trig_r <= reg_wr && reg_addr == ADDR_RESTART && reg_wdata[B_SWTRIG]
        && work_r[IX_RM_PRI][B_SNAPSHOT] && !halted;
    end
  end

  // Trigger pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
    end else begin
      trig_s1_r <= trigger_pin;
      trig_s2_r <= trig_s1_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trig_lvl_d_r <= 1'b0;
      trigger_evt <= 1'b0;
    end else begin
      trig_lvl_d_r <= trig_s2_r ^ work_r[IX_RM_PRI][B_INV_TRIG];
      trigger_evt <= ((trig_s2_r ^ work_r[IX_RM_PRI][B_INV_TRIG]) && !trig_lvl_d_r) || sw_trig_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      line_valid <= 1'b0;
    end else begin
      line_valid <= line_valid_raw && (frame_valid || work_r[IX_RM_PRI][B_CONT_LV]);
    end
  end

  // exposure, zero lower count treated as one
  assign lower_eff = (work_r[IX_SW_LOWER] == '0) ? 16'h0001 : work_r[IX_SW_LOWER];
  assign expo_prod = 36'({work_r[IX_SW_UPPER][F_UPPER_W-1:0], lower_eff}) * 36'(row_time);
  // trim is the low thirteen bits
  assign expo_cut = 36'(work_r[IX_SHUTTER_TRIM][F_TRIM_W-1:0]) + 36'(EXPO_FIXED);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      exposure_pixclks <= '0;
    end else begin
      exposure_pixclks <= (expo_prod > expo_cut) ? expo_prod - expo_cut : '0;
    end
  end

  assign st_start = work_r[IX_RM_PRI][3:2];
  assign st_end = work_r[IX_RM_PRI][1:0];
  assign short_pulse = (st_end <= st_start);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || halted || !work_r[IX_RM_PRI][B_STROBE_EN]) begin
      strobe_act_r <= 1'b0;
      strobe_cnt_r <= '0;
    end else if (!strobe_act_r && strobe_evt[st_start]) begin
      strobe_act_r <= 1'b1;
      strobe_cnt_r <= row_time;
    end else if (strobe_act_r) begin
      if (short_pulse) begin
        // one row time when end not after start
        if (pix_ce) begin
          strobe_cnt_r <= strobe_cnt_r - ROW_W'(1);
          if (strobe_cnt_r <= ROW_W'(1)) begin
            strobe_act_r <= 1'b0;
          end
        end
      end else if (strobe_evt[st_end]) begin
        strobe_act_r <= 1'b0;
      end
    end
  end

  // flash pin rests at the invert level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strobe <= 1'b0;
    end else begin
      strobe <= work_r[IX_RM_PRI][B_INV_STROBE] ^ strobe_act_r;
    end
  end

  // Working fields out to readout, clock and datapath logic
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      device_halted <= 1'b0;
      chip_enable <= 1'b0;
      synth_power <= 1'b0;
      synth_select <= 1'b0;
      synth_multiplier <= '0;
      synth_out_div <= '0;
      system_clock_divider <= '0;
    end else begin
      device_halted <= halted;
      chip_enable <= work_r[IX_OUT_CTL][B_CHIP_EN] && !halted;
      synth_power <= work_r[IX_SYNTH_CTL][B_SYN_PWR];
      synth_select <= work_r[IX_SYNTH_CTL][B_SYN_SEL];
      synth_multiplier <= work_r[IX_SYNTH_RATIO][15:8];
      synth_out_div <= work_r[IX_SYNTH_RATIO][5:0];
      system_clock_divider <= work_r[IX_SYNTH_POST][4:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      anti_bloom <= 1'b0;
      snapshot_mode <= 1'b0;
      global_shutter <= 1'b0;
      bulb_exposure <= 1'b0;
    end else begin
      anti_bloom <= work_r[IX_RM_PRI][B_ANTIBLOOM];
      snapshot_mode <= work_r[IX_RM_PRI][B_SNAPSHOT];
      global_shutter <= work_r[IX_RM_PRI][B_GLOBAL];
      bulb_exposure <= work_r[IX_RM_PRI][B_BULB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mirror_rows <= 1'b0;
      mirror_cols <= 1'b0;
      dark_cols <= 1'b0;
      dark_rows <= 1'b0;
      per_line_black_comp <= 1'b0;
      column_sum <= 1'b0;
    end else begin
      mirror_rows <= work_r[IX_RM_SEC][B_MIRROR_ROW];
      mirror_cols <= work_r[IX_RM_SEC][B_MIRROR_COL];
      dark_cols <= work_r[IX_RM_SEC][B_DARK_COLS];
      dark_rows <= work_r[IX_RM_SEC][B_DARK_ROWS];
      per_line_black_comp <= work_r[IX_RM_SEC][B_LINE_BLC];
      column_sum <= work_r[IX_RM_SEC][B_COL_SUM];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      row_bin <= '0;
      row_skip <= '0;
      col_bin <= '0;
      col_skip <= '0;
      first_green_digital_amp <= '0;
      first_green_doubler <= 1'b0;
      first_green_analog <= '0;
    end else begin
      row_bin <= work_r[IX_LINE_ADDR][5:4];
      row_skip <= work_r[IX_LINE_ADDR][2:0];
      col_bin <= work_r[IX_PIX_ADDR][5:4];
      col_skip <= work_r[IX_PIX_ADDR][2:0];
      // digital gain in eighths, unity added
      first_green_digital_amp <= 8'(F_GAIN_ONE) + {1'b0, work_r[IX_GREEN1][14:8]};
      first_green_doubler <= work_r[IX_GREEN1][B_DOUBLER];
      first_green_analog <= work_r[IX_GREEN1][5:0];
    end
  end

endmodule : irc_regs
`default_nettype wire

// file: test/irc_regs_monitor.sv
// Assertion checker for the readout control register bank
`timescale 1ns/1ps
`default_nettype none
module irc_regs_monitor
  import irc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [IRC_AW-1:0] reg_addr,
  input wire logic [IRC_DW-1:0] reg_rdata,
  input wire logic row_tick,
  input wire logic line_valid_raw,
  input wire logic line_valid,
  input wire logic restart_pulse,
  input wire logic device_halted,
  input wire logic chip_enable,
  input wire logic trigger_evt,
  input wire logic anti_bloom,
  input wire logic per_line_black_comp,
  input wire logic [7:0] first_green_digital_amp
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence halted_run;
    device_halted [*3];
  endsequence
  lv_gate_a: assert property (line_valid |-> $past(line_valid_raw))
    else $error("line valid without raw");
  restart_tick_a: assert property (restart_pulse |-> $past(row_tick))
    else $error("restart off row boundary");
  restart_once_a: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse too long");
  restart_read_a: assert property ($past(reg_addr) == ADDR_RESTART |-> reg_rdata[15:2] == 14'h0000)
    else $error("restart upper bits set");
  // Halt level lags its write by two cycles
  halt_keep_a: assert property (device_halted && !($past(reg_wr, 2) && $past(reg_addr, 2) == IRC_ADDR[IX_SOFT_HALT])
    |=> device_halted)
    else $error("halt dropped by itself");
  halt_chipoff_a: assert property (halted_run |-> !chip_enable)
    else $error("chip enabled while halted");
  halt_default_a: assert property (halted_run |-> anti_bloom && per_line_black_comp)
    else $error("defaults lost while halted");
  trig_pulse_a: assert property (trigger_evt |=> !trigger_evt)
    else $error("trigger event too long");
  gain_floor_a: assert property ($past(rst_n, 2) |-> first_green_digital_amp[7:3] != 5'h00)
    else $error("digital gain below one");
  restart_c: cover property (restart_pulse);
endmodule : irc_regs_monitor
bind irc_regs irc_regs_monitor irc_regs_monitor_i (.*);
`default_nettype wire

// file: test/irc_engine_model.sv
// Readout engine model making row and frame timing
`timescale 1ns/1ps
`default_nettype none
module irc_engine_model #(
  parameter int ROWLEN = 16,
  parameter int ROWS = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic restart_pulse,
  input wire logic hold_row0,
  output logic pix_ce,
  output logic frame_start,
  output logic row_tick,
  output logic frame_valid,
  output logic line_valid_raw,
  output logic [3:0] strobe_evt
);
  logic [7:0] col_r;
  logic [7:0] row_r;
  logic pix_r;
  logic park;
  assign park = hold_row0 && row_r == 8'h00;
  always_ff @(posedge ref_clk) begin
    pix_r <= rst_n ? ~pix_r : 1'b0;
    if (!rst_n || restart_pulse) begin
      col_r <= 8'h00;
      row_r <= 8'h00;
    end else if (!park) begin
      col_r <= (col_r == 8'(ROWLEN - 1)) ? 8'h00 : col_r + 8'h01;
      if (col_r == 8'(ROWLEN - 1)) begin
        row_r <= (row_r == 8'(ROWS - 1)) ? 8'h00 : row_r + 8'h01;
      end
    end
  end
  assign pix_ce = pix_r;
  assign row_tick = !park && col_r == 8'h00;
  assign frame_start = row_tick && row_r == 8'h00;
  assign frame_valid = row_r >= 8'h01 && row_r <= 8'h05;
  assign line_valid_raw = col_r >= 8'h04 && col_r <= 8'h0B;
  assign strobe_evt = {4{row_tick}} & {row_r == 8'h06, row_r == 8'h04, row_r == 8'h02, row_r == 8'h01};
endmodule : irc_engine_model
`default_nettype wire

// file: test/tb_top.sv
// Testbench for the readout control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import irc_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [IRC_AW-1:0] reg_addr = 8'h00;
  logic [IRC_DW-1:0] reg_wdata = 16'h0000;
  logic [15:0] row_time = 16'h0008;
  logic trigger_pin = 1'b0;
  logic [IRC_DW-1:0] reg_rdata;
  logic pix_ce, frame_start, row_tick, frame_valid, line_valid_raw, line_valid, restart_pulse, hold_row0;
  logic device_halted, chip_enable, trigger_evt, synth_power, synth_select, anti_bloom, snapshot_mode;
  logic global_shutter, bulb_exposure, strobe, mirror_rows, mirror_cols, dark_cols, dark_rows;
  logic per_line_black_comp, column_sum, first_green_doubler;
  logic [3:0] strobe_evt;
  logic [35:0] exposure_pixclks;
  logic [7:0] synth_multiplier, first_green_digital_amp;
  logic [5:0] synth_out_div, first_green_analog;
  logic [4:0] system_clock_divider;
  logic [1:0] row_bin, col_bin;
  logic [2:0] row_skip, col_skip;
  logic [7:0] ra [10] = '{8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h1E, 8'h20, 8'h22, 8'h23, 8'h2B};
  logic [15:0] rv [10] = '{16'h0000, 16'h0000, 16'h0050, 16'h6404, 16'h0000, 16'h4006, 16'h0040,
    16'h0000, 16'h0000, 16'h0008};
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  int nl;
  int ns;
  always #4 ref_clk = ~ref_clk;
  irc_regs irc_regs_i (.*);
  irc_engine_model irc_engine_model_i (.*);
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    step(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    step(1);
    reg_addr = a;
    step(1);
    chk(nm, e, reg_rdata);
  endtask : rd
  task automatic wait_fs();
    do step(1); while (frame_start !== 1'b1);
    step(1);
  endtask : wait_fs
  task automatic measure();
    wait_fs();
    wait_fs();
    nl = 0;
    ns = 0;
    repeat (128) begin
      step(1);
      nl += int'(line_valid === 1'b1 && frame_valid === 1'b0);
      ns += int'(strobe === 1'b1);
    end
  endtask : measure
  task automatic trig(input logic v);
    trigger_pin = v;
    k = 0;
    repeat (8) begin
      step(1);
      if (trigger_evt === 1'b1) k = 1;
    end
    chk("trigger_evt", 1, k);
  endtask : trig
  task automatic wait_pulse();
    k = 0;
    repeat (32) begin
      step(1);
      if (restart_pulse === 1'b1) k = 1;
    end
    chk("restart_pulse", 1, k);
  endtask : wait_pulse
  initial begin
    step(10);
    rst_n = 1'b1;
    for (k = 0; k < 10; k++) begin
      rd(ra[k], rv[k], "reset value");
    end
    chk("anti_bloom", 1, anti_bloom);
    chk("chip_enable", 1, chip_enable);
    $display("test defaults done");
    wr(8'h10, 16'h0003);
    wr(8'h11, 16'h643F);
    wr(8'h12, 16'h001F);
    step(3);
    chk("synth_power", 1, synth_power);
    chk("synth_select", 1, synth_select);
    chk("synth_out_div", 6'h3F, synth_out_div);
    chk("system_clock_divider", 5'h1F, system_clock_divider);
    chk("synth_multiplier", 8'h64, synth_multiplier);
    wr(8'h10, 16'h0001);
    step(3);
    chk("synth_select", 0, synth_select);
    trig(1'b1);
    wr(8'h1E, 16'h4206);
    step(3);
    trig(1'b0);
    $display("test clocks and trigger done");
    wr(8'h1E, 16'h07D6);
    wr(8'h20, 16'hD860);
    measure();
    chk("anti_bloom", 0, anti_bloom);
    chk("snapshot_mode", 1, snapshot_mode);
    chk("global_shutter", 1, global_shutter);
    chk("bulb_exposure", 1, bulb_exposure);
    chk("mirror", 2'b11, {mirror_rows, mirror_cols});
    chk("dark", 2'b11, {dark_cols, dark_rows});
    chk("per_line_black_comp", 1, per_line_black_comp);
    chk("column_sum", 1, column_sum);
    chk("blank line valid", 24, nl);
    chk("strobe width", 32, ns);
    wr(8'h0B, 16'h0004);
    step(1);
    chk("software trigger", 1, trigger_evt);
    wr(8'h1E, 16'h0019);
    measure();
    chk("blank line valid", 0, nl);
    chk("one row strobe", 1, ns >= 15 && ns <= 17);
    chk("modes", 3'b000, {snapshot_mode, global_shutter, bulb_exposure});
    wr(8'h1E, 16'h0020);
    step(3);
    chk("strobe idle", 1, strobe);
    wr(8'h1E, 16'h0000);
    step(3);
    chk("strobe idle", 0, strobe);
    $display("test readout modes done");
    wait_fs();
    wr(8'h2B, 16'h7840);
    step(3);
    chk("gain before frame", 8'h08, first_green_digital_amp);
    wait_fs();
    wait_fs();
    chk("gain", 8'h80, first_green_digital_amp);
    chk("first_green_doubler", 1, first_green_doubler);
    chk("first_green_analog", 6'h00, first_green_analog);
    wr(8'h07, 16'h0003);
    wr(8'h22, 16'h0027);
    wr(8'h23, 16'h0036);
    wait_fs();
    wait_fs();
    chk("held row_skip", 0, row_skip);
    wr(8'h07, 16'h0002);
    wait_fs();
    wait_fs();
    chk("row bin skip", 5'h17, {row_bin, row_skip});
    chk("col bin skip", 5'h1E, {col_bin, col_skip});
    wr(8'h09, 16'h0010);
    wr(8'h08, 16'h0001);
    wr(8'h0C, 16'hE005);
    wait_fs();
    wait_fs();
    chk("exposure", 36'h10010 * 8 - 5, exposure_pixclks);
    $display("test frame sync done");
    wr(8'h0D, 16'h0001);
    wr(8'h1E, 16'h0000);
    step(4);
    chk("device_halted", 1, device_halted);
    chk("chip_enable", 0, chip_enable);
    rd(8'h1E, 16'h4006, "halted write");
    rd(8'h2B, 16'h0008, "halt default");
    wr(8'h0D, 16'h0000);
    step(3);
    chk("device_halted", 0, device_halted);
    chk("chip_enable", 1, chip_enable);
    wr(8'h0B, 16'h0001);
    wait_pulse();
    rd(8'h0B, 16'h0000, "restart bit");
    wr(8'h0B, 16'h0003);
    wait_pulse();
    chk("hold_row0", 1, hold_row0);
    rd(8'h0B, 16'h0003, "restart bit held");
    wr(8'h0B, 16'h0000);
    step(3);
    chk("hold_row0", 0, hold_row0);
    $display("test halt and restart done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
